// File: crdc_pkg.sv
// package: register map, field layout, reset values and ladder constants for the reference control block
// Summary of operation
// - top bit powers ladder on or off
// - pin drive bit connects level to pin
// - range bit selects low or high range
// - tap code sets ladder tap level
// - source bit selects external or rail span
// - any reset clears control register to zero
// - sleep wake leaves register contents unchanged
// - reference settings ignore comparator state
// - route reference to comparators in mode 110
package crdc_pkg;
    localparam int              ADDR_WIDTH       = 4;
    localparam logic [3:0]      LEVEL_CTRL_ADDR  = 4'h0;
    localparam logic [3:0]      COMP_MODE_ADDR   = 4'h4;
    localparam logic [3:0]      STATUS_ADDR      = 4'h8;
    localparam logic [7:0]      LEVEL_CTRL_RESET = 8'h00;
    localparam logic [2:0]      COMP_MODE_RESET  = 3'h0;
    localparam logic [2:0]      MODE_INTERNAL    = 3'h6;
    localparam int              POWER_BIT        = 7;
    localparam int              PIN_DRIVE_BIT    = 6;
    localparam int              LOW_RANGE_BIT    = 5;
    localparam int              EXT_SOURCE_BIT   = 4;
    localparam int              TAP_MSB          = 3;
    localparam int              TAP_LSB          = 0;
    localparam int              LOW_RANGE_STEPS  = 24;
    localparam int              HIGH_RANGE_STEPS = 32;
    localparam int              HIGH_RANGE_BASE  = 8;
endpackage

// File: crdc_top.sv
// module: reference ladder control register and static control outputs
module crdc_top (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [3:0]  address,
    input  wire logic [7:0]  write_data,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    output logic      [7:0]  read_data,
    output logic             ladder_power_on,
    output logic             ladder_pin_drive,
    output logic             ladder_low_range,
    output logic             ladder_external_source,
    output logic      [3:0]  ladder_tap_code,
    output logic             comparator_internal_ref
);
    logic [7:0] reference_level_control;
    logic [7:0] next_reference_level_control;
    logic [2:0] comparator_mode_field;
    logic [2:0] next_comparator_mode_field;
    logic [7:0] next_read_data;
    logic [7:0] out_bits;
    logic [7:0] next_out_bits;
    logic       next_internal_ref;

    // address decode shared by the write path and the checks; the read path decodes with its own case
    function automatic logic crdc_hits(input logic [3:0] a, input logic [3:0] target);
        return a == target;
    endfunction

    // register writes; sleep has no port here, so contents survive wake untouched
    always_comb begin
        next_reference_level_control = reference_level_control;
        next_comparator_mode_field   = comparator_mode_field;
        if (write_strobe && crdc_hits(address, crdc_pkg::LEVEL_CTRL_ADDR)) begin
            next_reference_level_control = write_data;
        end
        if (write_strobe && crdc_hits(address, crdc_pkg::COMP_MODE_ADDR)) begin
            next_comparator_mode_field = write_data[2:0];
        end
    end

    // reset clears everything; otherwise only a write to a mapped address changes a register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reference_level_control <= crdc_pkg::LEVEL_CTRL_RESET;
            comparator_mode_field   <= crdc_pkg::COMP_MODE_RESET;
        end else begin
            reference_level_control <= next_reference_level_control;
            comparator_mode_field   <= next_comparator_mode_field;
        end
    end

    // outputs follow the written value one edge after the write, no comparator term
    always_comb begin
        next_out_bits     = next_reference_level_control;
        next_internal_ref = (next_comparator_mode_field == crdc_pkg::MODE_INTERNAL);
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        next_read_data = 8'h00;
        if (read_strobe) begin
            case (address)
                crdc_pkg::LEVEL_CTRL_ADDR: next_read_data = reference_level_control;
                crdc_pkg::COMP_MODE_ADDR:  next_read_data = {5'h00, comparator_mode_field};
                crdc_pkg::STATUS_ADDR:     next_read_data = {7'h00, comparator_internal_ref};
                default:                   next_read_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_bits                <= crdc_pkg::LEVEL_CTRL_RESET;
            comparator_internal_ref <= 1'b0;
            read_data               <= 8'h00;
        end else begin
            out_bits                <= next_out_bits;
            comparator_internal_ref <= next_internal_ref;
            read_data               <= next_read_data;
        end
    end

    // field split; pin direction is software's duty before drive is set
    assign ladder_power_on        = out_bits[crdc_pkg::POWER_BIT];
    assign ladder_pin_drive       = out_bits[crdc_pkg::PIN_DRIVE_BIT];
    assign ladder_low_range       = out_bits[crdc_pkg::LOW_RANGE_BIT];
    assign ladder_external_source = out_bits[crdc_pkg::EXT_SOURCE_BIT];
    assign ladder_tap_code        = out_bits[crdc_pkg::TAP_MSB:crdc_pkg::TAP_LSB];

    AST_POWER_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && address == crdc_pkg::LEVEL_CTRL_ADDR) |=> ladder_power_on == $past(write_data[7]))
        else $error("power bit not applied");
    AST_PIN_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && address == crdc_pkg::LEVEL_CTRL_ADDR) |=> ladder_pin_drive == $past(write_data[6]))
        else $error("pin drive bit not applied");
    AST_RANGE_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && address == crdc_pkg::LEVEL_CTRL_ADDR) |=> ladder_low_range == $past(write_data[5]))
        else $error("range bit not applied");
    AST_TAP_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && address == crdc_pkg::LEVEL_CTRL_ADDR) |=> ladder_tap_code == $past(write_data[3:0]))
        else $error("tap code not applied");
    AST_SOURCE_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && address == crdc_pkg::LEVEL_CTRL_ADDR) |=> ladder_external_source == $past(write_data[4]))
        else $error("source bit not applied");
    AST_HOLD_STEADY: assert property (@(posedge clock) disable iff (!reset_n)
        !(write_strobe && address == crdc_pkg::LEVEL_CTRL_ADDR) |=> $stable(out_bits))
        else $error("outputs moved without a write");
    AST_MODE_INDEPENDENT: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && address == crdc_pkg::COMP_MODE_ADDR) |=> $stable(out_bits))
        else $error("comparator mode changed reference");
    AST_INTERNAL_ROUTE: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 comparator_internal_ref == ($past(next_comparator_mode_field) == crdc_pkg::MODE_INTERNAL))
        else $error("internal route wrong");
    AST_READBACK: assert property (@(posedge clock) disable iff (!reset_n)
        (read_strobe && address == crdc_pkg::LEVEL_CTRL_ADDR) |=> read_data == out_bits)
        else $error("readback differs from outputs");

    // reset is checked while it is held, so the asynchronous clear is seen at every edge
    AST_RESET_CLEAR: assert property (@(posedge clock)
        !reset_n |-> (out_bits == crdc_pkg::LEVEL_CTRL_RESET && read_data == 8'h00 && !comparator_internal_ref))
        else $error("reset did not clear the controls");
    // the ladder outputs and the register copy never drift apart
    AST_OUT_MATCHES_REG: assert property (@(posedge clock) disable iff (!reset_n)
        out_bits == reference_level_control)
        else $error("ladder outputs differ from register");
    AST_MODE_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && crdc_hits(address, crdc_pkg::COMP_MODE_ADDR))
        |=> comparator_mode_field == $past(write_data[2:0]))
        else $error("mode field not written");
    AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
        (write_strobe && !crdc_hits(address, crdc_pkg::LEVEL_CTRL_ADDR)
         && !crdc_hits(address, crdc_pkg::COMP_MODE_ADDR)) |=> ($stable(out_bits) && $stable(comparator_mode_field)))
        else $error("unmapped write changed state");
    AST_READ_IDLE_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
        !read_strobe |=> read_data == 8'h00)
        else $error("read data outside read cycle");
    AST_READ_MODE: assert property (@(posedge clock) disable iff (!reset_n)
        (read_strobe && crdc_hits(address, crdc_pkg::COMP_MODE_ADDR))
        |=> read_data == {5'h00, $past(comparator_mode_field)})
        else $error("mode readback wrong");
    AST_READ_STATUS: assert property (@(posedge clock) disable iff (!reset_n)
        (read_strobe && crdc_hits(address, crdc_pkg::STATUS_ADDR))
        |=> read_data == {7'h00, $past(comparator_internal_ref)})
        else $error("status readback wrong");

    COV_POWER_UP: cover property (@(posedge clock) disable iff (!reset_n) $rose(ladder_power_on));
    COV_LOW_RANGE: cover property (@(posedge clock) disable iff (!reset_n) ladder_power_on && ladder_low_range);
    COV_PIN_EXT: cover property (@(posedge clock) disable iff (!reset_n) ladder_pin_drive && ladder_external_source);
    COV_INTERNAL: cover property (@(posedge clock) disable iff (!reset_n) $rose(comparator_internal_ref));
endmodule

// File: crdc_ladder_model.sv
// ladder partner: tap level in 96ths of the span and the level seen on the shared pin
module crdc_ladder_model (
    input  wire logic       power_on,
    input  wire logic       pin_drive,
    input  wire logic       low_range,
    input  wire logic [3:0] tap_code,
    output int              level_96,
    output int              pin_96
);
    timeunit 1ns;
    timeprecision 1ps;
    // 96ths hold both step sizes exactly; an unpowered ladder gives no level
    assign level_96 = !power_on ? 0 : low_range ? 4 * tap_code : 24 + 3 * tap_code;
    // a released pin reads as -1, never as a stale level
    assign pin_96 = pin_drive ? level_96 : -1;
endmodule

// File: comparator_reference_dac_control_tb.sv
// self-checking bench for the reference ladder control block
module comparator_reference_dac_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock = 0, reset_n = 0, write_strobe = 0, read_strobe = 0, rd_pend = 0;
    logic [3:0] address = 4'h0, tap;
    logic [7:0] write_data = 8'h00, read_data, exp_q[$];
    logic       pwr, drv, low, ext, cref;
    int         level_96, pin_96, fails = 0, cmp_count = 0;
    always #2.5 clock = ~clock;
    crdc_top dut (.clock(clock), .reset_n(reset_n), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .ladder_power_on(pwr),
        .ladder_pin_drive(drv), .ladder_low_range(low), .ladder_external_source(ext), .ladder_tap_code(tap),
        .comparator_internal_ref(cref));
    crdc_ladder_model ladder (.power_on(pwr), .pin_drive(drv), .low_range(low), .tap_code(tap),
        .level_96(level_96), .pin_96(pin_96));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        address <= a;
        read_strobe <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        read_strobe <= 1'b0;
        @(posedge clock);
    endtask
    // ladder outputs and the partner's level against the value written, sampled mid-cycle
    task automatic chk(input logic [7:0] v);
        int e;
        e = !v[7] ? 0 : v[5] ? 4 * int'(v[3:0]) : 24 + 3 * int'(v[3:0]);
        @(negedge clock);
        check({pwr, drv, low, ext, tap}, v, "ladder controls");
        check(level_96, e, "ladder level");
        check(pin_96, v[6] ? e : -1, "pin level");
        @(posedge clock);
    endtask
    // read data stand only in the cycle after the strobe and are zero otherwise
    always @(posedge clock) rd_pend <= read_strobe;
    always @(negedge clock) check(read_data, rd_pend ? exp_q.pop_front() : 8'h00, "read data");
    initial #60000 begin
        fails++;
        close_out();
    end
    initial begin
        logic [7:0] v;
        v = 8'h00;
        void'($urandom(15));
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk(8'h00);
        rd(4'h0, 8'h00);
        // every tap code in both ranges, other control bits random; the bench stands in for
        // software, whose pin direction and converter setup duties lie outside this port
        for (int i = 0; i < 32; i++) begin
            v = 8'(($urandom & 32'hd0) | (i & 32'h0f) | ((i & 32'h10) << 1));
            wr(4'h0, v);
            chk(v);
            rd(4'h0, v);
        end
        $display("test done: control writes");
        for (int m = 0; m < 8; m++) begin
            wr(4'h4, 8'(m) | 8'hf8);
            chk(v);
            check(cref, m == 6, "internal route");
            rd(4'h4, 8'(m));
            rd(4'h8, 8'(m == 6));
        end
        wr(4'hc, 8'h3c);
        rd(4'hc, 8'h00);
        repeat (20) @(posedge clock);
        chk(v);
        wr(4'h0, 8'h00);
        chk(8'h00);
        $display("test done: mode, unmapped and hold");
        reset_n <= 1'b0;
        @(posedge clock);
        chk(8'h00);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(4'h0, 8'h00);
        @(posedge clock);
        $display("test done: reset in mid-run");
        close_out();
    end
endmodule
